/* include/clock_gen_pkg.sv */
// Package of the clock generator: register map, field layout, reset
// values, state encoding and timing counts.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package clock_gen_pkg;

    // ==================================================================
    // Clock and timing
    // ==================================================================
    localparam int unsigned CLK_MHZ = 125;
    // Settling time unit; the selected time is this unit times 2**sel.
    localparam int unsigned SETTLE_UNIT_NS = 2048;
    localparam int unsigned SETTLE_BASE_CYC =
        (SETTLE_UNIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETTLE_W = 24;
    localparam int unsigned SUB_DIV = 128;
    localparam int unsigned MED_DIV_MAX = 32;

    // ==================================================================
    // Register offsets (byte addresses)
    // ==================================================================
    localparam logic [3:0] OFS_SYSTEM_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] OFS_LOW_POWER_CONTROL = 4'h4;
    localparam logic [3:0] OFS_STANDBY_CONTROL = 4'h8;
    localparam logic [3:0] OFS_CLOCK_STATUS = 4'hc;

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int unsigned POS_BUS_CLOCK_SEL_LO = 0;
    localparam int unsigned POS_BUS_CLOCK_SEL_HI = 2;
    localparam int unsigned POS_FACTOR_SWITCH_MODE = 3;
    localparam int unsigned POS_PLL_FACTOR_BIT_LO = 0;
    localparam int unsigned POS_PLL_FACTOR_BIT_HI = 1;
    localparam int unsigned POS_STANDBY_ENTER = 0;
    localparam int unsigned POS_SETTLE_TIME_SEL_LO = 4;
    localparam int unsigned POS_SETTLE_TIME_SEL_HI = 6;
    localparam int unsigned POS_STAT_HALTED = 2;
    localparam int unsigned POS_STAT_SETTLING = 3;
    localparam int unsigned POS_STAT_SEL_LO = 4;
    localparam int unsigned POS_STAT_SEL_HI = 6;

    // ==================================================================
    // Reset values and encodings
    // ==================================================================
    localparam logic [1:0] FACTOR_X1 = 2'h0;
    localparam logic [1:0] FACTOR_X2 = 2'h1;
    localparam logic [1:0] FACTOR_X4 = 2'h2;
    localparam logic [1:0] FACTOR_BAD = 2'h3;
    localparam logic [2:0] BUS_SEL_FULL = 3'h0;
    localparam logic [2:0] BUS_SEL_LIMIT = 3'h5;
    localparam logic [2:0] SETTLE_SEL_RESET = 3'h0;
    localparam logic FACTOR_MODE_RESET = 1'b0;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_STANDBY,
        ST_SETTLE
    } clk_state_e;

endpackage : clock_gen_pkg

`default_nettype wire

/* verif/clock_gen_top_tb_top.sv */
// Bench for the clock generator: registers, factors, standby, dividers.
// Assumes clock_gen_pkg and the osc_source oscillator model.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_top_tb_top
    import clock_gen_pkg::*;
;
    // =================================================================
    // Signals
    localparam int SB = 8;
    logic clk, arst_n, read, write, wake_req, osc, waitrequest;
    logic phi_en, sub_en, bus_clk_en, clocks_halted;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rd;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int c, k;
    clock_gen_top #(.SETTLE_BASE(SB)) dut (.clk(clk), .arst_n(arst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .osc_input_pin(osc), .wake_req(wake_req), .phi_en(phi_en),
        .sub_en(sub_en), .bus_clk_en(bus_clk_en),
        .clocks_halted(clocks_halted));
    osc_source #(.HALF(20)) src (.clk(clk), .pin(osc));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The longest scenario set needs about 15000 cycles.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    // =================================================================
    // Helpers
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    function automatic logic sig(input int s);
        return s == 0 ? phi_en : s == 1 ? bus_clk_en :
            s == 2 ? sub_en : ~clocks_halted;
    endfunction : sig
    task automatic cnt(input int s, input int n);
        c = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (sig(s) === 1'b1)
                c++;
        end
    endtask : cnt
    task automatic wait_hi(input int s, input int lim);
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (sig(s) !== 1'b1 && k < lim);
    endtask : wait_hi
    // =================================================================
    // Scenarios
    task automatic t_reset();
        bus(1'b0, OFS_CLOCK_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h2, 32'hff);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        @(posedge osc);
        wait_hi(0, 12);
        chk(k >= 3 && k <= 7, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_factor();
        bus(1'b1, OFS_SYSTEM_CLOCK_CONTROL, 32'h8);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, OFS_LOW_POWER_CONTROL, i);
            repeat (100) @(posedge clk);
            cnt(0, 160);
            chk(c, 4 << i);
        end
        bus(1'b1, OFS_LOW_POWER_CONTROL, 32'h3);
        bus(1'b0, OFS_CLOCK_STATUS, 32'h0);
        chk(rd[1:0], FACTOR_X4);
        $display("test factor done");
    endtask : t_factor
    task automatic t_standby();
        bus(1'b1, OFS_SYSTEM_CLOCK_CONTROL, 32'h0);
        bus(1'b1, OFS_STANDBY_CONTROL, 32'h10);
        bus(1'b1, OFS_LOW_POWER_CONTROL, 32'h0);
        repeat (100) @(posedge clk);
        cnt(0, 160);
        chk(c, 16);
        bus(1'b1, OFS_STANDBY_CONTROL, 32'h11);
        cnt(0, 100);
        chk({clocks_halted, c[7:0]}, 9'h100);
        bus(1'b0, OFS_CLOCK_STATUS, 32'h0);
        chk(rd[3:0], {2'b01, FACTOR_X1});
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        cnt(0, 2 * SB - 2);
        chk({clocks_halted, c[7:0]}, 9'h100);
        wait_hi(3, 8);
        chk(k, 3);
        repeat (100) @(posedge clk);
        cnt(0, 160);
        chk(c, 4);
        $display("test standby done");
    endtask : t_standby
    task automatic t_bus();
        bus(1'b1, OFS_SYSTEM_CLOCK_CONTROL, 32'h8);
        bus(1'b1, OFS_LOW_POWER_CONTROL, 32'h2);
        for (int s = 0; s < 6; s++)
        begin
            bus(1'b1, OFS_SYSTEM_CLOCK_CONTROL, 32'h8 | s);
            repeat (400) @(posedge clk);
            cnt(1, 640);
            chk(c, 64 >> s);
        end
        bus(1'b1, OFS_SYSTEM_CLOCK_CONTROL, 32'he);
        bus(1'b0, OFS_CLOCK_STATUS, 32'h0);
        chk(rd[6:4], BUS_SEL_LIMIT);
        wait_hi(2, 6000);
        wait_hi(2, 6000);
        chk(k, 5120);
        $display("test bus done");
    endtask : t_bus
    initial
    begin
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        wake_req = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_factor();
        t_standby();
        t_bus();
        report_and_stop();
    end
endmodule : clock_gen_top_tb_top
`default_nettype wire

/* verif/osc_source.sv */
// Model of the external oscillator that drives the clock input pin.
// Assumes clk is the system clock; the pin period is 2*HALF cycles.
`timescale 1ns/1ps
`default_nettype none
module osc_source
#(
    parameter int HALF = 20
)
(
    input wire logic clk,
    output logic pin
);
    int n = 0;
    logic level = 1'b0;
    // An oscillator runs free, so the pin keeps toggling in standby too.
    always @(posedge clk)
    begin
        n <= (n == HALF - 1) ? 0 : n + 1;
        if (n == HALF - 1)
            level <= ~level;
    end
    assign pin = level;
endmodule : osc_source
`default_nettype wire

/* verilog/clock_gen_top.sv */
// Clock generator: oscillator multiplier with phase alignment, factor
// switching through standby, subclock and medium-speed dividers and the
// bus master clock selector. All clocks leave as one-cycle enables.
// Assumes an Avalon-MM master and an oscillator pin far slower than clk.
//
// Function
// - Multiply oscillator rate by one, two or four per the factor field.
// - Internal clock rising edge follows the oscillator pin rising edge.
// - With switch mode 0, a new factor waits for software standby.
// - On standby exit, count the settling time chosen by the select field.
// - After reset the active factor is one.
// - Standby entry stops the system and bus clocks and loads the pending factor.
// - Clocks resume only after settling, at the new factor.
// - Subclock is the oscillator clock divided by 128.
// - Medium-speed clocks divide the system clock by 2 to 32.
// - Bus masters get full speed or one divided clock per select field.
// - With switch mode 1, a new factor takes effect at once.
// - Factor 00 is x1, 01 x2, 10 x4; 11 is refused.
// - Select 000 full, 001..101 divide by 2..32; 11X is refused.
`timescale 1ns/1ps
`default_nettype none

module clock_gen_top
    import clock_gen_pkg::*;
#(
    parameter int unsigned PERIOD_W = 16,
    parameter int unsigned SETTLE_BASE = SETTLE_BASE_CYC
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic osc_input_pin,
    input wire logic wake_req,
    output logic phi_en,
    output logic sub_en,
    output logic bus_clk_en,
    output logic clocks_halted
);

    if (PERIOD_W < 4 || SETTLE_BASE < 1 ||
        (SETTLE_BASE << 7) >= (1 << SETTLE_W))
    begin : g_bad_param
        $error("clock_gen_top parameters out of range");
    end

    clk_state_e state;
    logic [1:0] pending_factor;
    logic [1:0] active_factor;
    logic factor_switch_mode;
    logic [2:0] bus_clock_sel;
    logic [2:0] active_sel;
    logic [2:0] settle_time_sel;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [PERIOD_W-1:0] per_cnt;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] pcnt;
    logic [1:0] pulses_left;
    logic osc_level;
    logic osc_rise;
    logic next_phi;
    logic tap_hit;
    logic [4:0] med_cnt;
    logic wr_acc;
    logic wr_scc;
    logic wr_lpc;
    logic wr_sbc;
    logic enter_req;
    logic [1:0] wr_factor;
    logic [2:0] wr_sel;
    logic [31:0] rd_mux;

    // ==================================================================
    // Oscillator pin and fixed dividers
    // ==================================================================
    pin_sync u_osc_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(osc_input_pin),
        .level(osc_level),
        .rise(osc_rise)
    );

    // The subclock keeps running in standby; only the system and bus clocks stop.
    enable_divider #(.DIV(SUB_DIV)) u_sub_div (
        .clk(clk),
        .arst_n(arst_n),
        .en(osc_rise),
        .count(),
        .tick(sub_en)
    );

    enable_divider #(.DIV(MED_DIV_MAX)) u_med_div (
        .clk(clk),
        .arst_n(arst_n),
        .en(next_phi),
        .count(med_cnt),
        .tick()
    );

    // ==================================================================
    // Avalon-MM slave: one wait cycle, then the answer
    // ==================================================================
    assign wr_acc = write && !waitrequest && byteenable[0];
    assign wr_scc = wr_acc && (address == OFS_SYSTEM_CLOCK_CONTROL);
    assign wr_lpc = wr_acc && (address == OFS_LOW_POWER_CONTROL);
    assign wr_sbc = wr_acc && (address == OFS_STANDBY_CONTROL);
    assign wr_factor = writedata[POS_PLL_FACTOR_BIT_HI:
                                 POS_PLL_FACTOR_BIT_LO];
    assign wr_sel = writedata[POS_BUS_CLOCK_SEL_HI:POS_BUS_CLOCK_SEL_LO];
    assign enter_req = wr_sbc && writedata[POS_STANDBY_ENTER] &&
                       (state == ST_RUN);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            waitrequest <= 1'b1;
        end
        else
        begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    always_comb
    begin
        rd_mux = 32'h0;
        if (address == OFS_SYSTEM_CLOCK_CONTROL)
        begin
            rd_mux[POS_FACTOR_SWITCH_MODE] = factor_switch_mode;
            rd_mux[POS_BUS_CLOCK_SEL_HI:POS_BUS_CLOCK_SEL_LO] =
                bus_clock_sel;
        end
        else if (address == OFS_LOW_POWER_CONTROL)
        begin
            rd_mux[POS_PLL_FACTOR_BIT_HI:POS_PLL_FACTOR_BIT_LO] =
                pending_factor;
        end
        else if (address == OFS_STANDBY_CONTROL)
        begin
            rd_mux[POS_SETTLE_TIME_SEL_HI:POS_SETTLE_TIME_SEL_LO] =
                settle_time_sel;
        end
        else if (address == OFS_CLOCK_STATUS)
        begin
            rd_mux[POS_PLL_FACTOR_BIT_HI:POS_PLL_FACTOR_BIT_LO] =
                active_factor;
            rd_mux[POS_STAT_HALTED] = (state != ST_RUN);
            rd_mux[POS_STAT_SETTLING] = (state == ST_SETTLE);
            rd_mux[POS_STAT_SEL_HI:POS_STAT_SEL_LO] = active_sel;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            readdata <= 32'h0;
        end
        else if (read && waitrequest)
        begin
            readdata <= rd_mux;
        end
    end

    // ==================================================================
    // Control registers
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            factor_switch_mode <= FACTOR_MODE_RESET;
            bus_clock_sel <= BUS_SEL_FULL;
        end
        else if (wr_scc)
        begin
            factor_switch_mode <= writedata[POS_FACTOR_SWITCH_MODE];
            if (wr_sel <= BUS_SEL_LIMIT)
            begin
                bus_clock_sel <= wr_sel;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pending_factor <= FACTOR_X1;
        end
        else if (wr_lpc && wr_factor != FACTOR_BAD)
        begin
            pending_factor <= wr_factor;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            settle_time_sel <= SETTLE_SEL_RESET;
        end
        else if (wr_sbc)
        begin
            settle_time_sel <= writedata[POS_SETTLE_TIME_SEL_HI:
                                         POS_SETTLE_TIME_SEL_LO];
        end
    end

    // ==================================================================
    // Standby sequence and active factor
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_RUN;
            settle_cnt <= '0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (enter_req)
                    begin
                        state <= ST_STANDBY;
                    end
                end
                ST_STANDBY:
                begin
                    if (wake_req)
                    begin
                        state <= ST_SETTLE;
                        settle_cnt <= SETTLE_W'(SETTLE_BASE) <<
                                      settle_time_sel;
                    end
                end
                ST_SETTLE:
                begin
                    settle_cnt <= settle_cnt - 1'b1;
                    if (settle_cnt == SETTLE_W'(1))
                    begin
                        state <= ST_RUN;
                    end
                end
                default:
                begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // A factor written in mode 0 only shows in the pending copy.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_factor <= FACTOR_X1;
        end
        else if (enter_req)
        begin
            active_factor <= pending_factor;
        end
        else if (wr_lpc && factor_switch_mode && wr_factor != FACTOR_BAD)
        begin
            active_factor <= wr_factor;
        end
    end

    // ==================================================================
    // Multiplier: the last oscillator period is split into 1, 2 or 4
    // slots, and each oscillator rise restarts the train so the phase
    // cannot drift. A change of oscillator rate takes one period to learn.
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            per_cnt <= '0;
            period <= '0;
        end
        else if (osc_rise)
        begin
            period <= PERIOD_W'(per_cnt + 1'b1);
            per_cnt <= '0;
        end
        else if (per_cnt != '1)
        begin
            per_cnt <= PERIOD_W'(per_cnt + 1'b1);
        end
    end

    assign next_phi = (state == ST_RUN) &&
                      (osc_rise ||
                       (pulses_left != 2'h0 &&
                        PERIOD_W'(pcnt + 1'b1) ==
                        (period >> active_factor)));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcnt <= '0;
            pulses_left <= 2'h0;
        end
        else if (osc_rise)
        begin
            pcnt <= '0;
            pulses_left <= 2'((3'h1 << active_factor) - 1'b1);
        end
        else if (next_phi)
        begin
            pcnt <= '0;
            pulses_left <= pulses_left - 1'b1;
        end
        else if (pcnt != '1)
        begin
            pcnt <= PERIOD_W'(pcnt + 1'b1);
        end
    end

    // ==================================================================
    // Bus master clock selection
    // ==================================================================
    always_comb
    begin
        case (active_sel)
            3'h1: tap_hit = med_cnt[0];
            3'h2: tap_hit = &med_cnt[1:0];
            3'h3: tap_hit = &med_cnt[2:0];
            3'h4: tap_hit = &med_cnt[3:0];
            3'h5: tap_hit = &med_cnt[4:0];
            default: tap_hit = 1'b1;
        endcase
    end

    // Switching while every tap fires at once leaves no short pulse.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_sel <= BUS_SEL_FULL;
        end
        else if ((next_phi && med_cnt == 5'h1f) || state != ST_RUN)
        begin
            active_sel <= bus_clock_sel;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phi_en <= 1'b0;
            bus_clk_en <= 1'b0;
            clocks_halted <= 1'b0;
        end
        else
        begin
            phi_en <= next_phi;
            bus_clk_en <= next_phi && tap_hit;
            clocks_halted <= (state != ST_RUN) || enter_req;
        end
    end

    // ==================================================================
    // Checks
    // ==================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic [2:0] phi_seen;
    logic factor_moved;
    logic [SETTLE_W-1:0] settle_elapsed;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phi_seen <= 3'h0;
            factor_moved <= 1'b0;
            settle_elapsed <= '0;
        end
        else
        begin
            phi_seen <= osc_rise ? 3'(next_phi) :
                        3'(phi_seen + 3'(next_phi));
            settle_elapsed <= (state == ST_SETTLE) ?
                              SETTLE_W'(settle_elapsed + 1'b1) : '0;
            // A factor change mid-period leaves a stale pulse train.
            factor_moved <= !osc_rise &&
                            (factor_moved || wr_lpc || enter_req);
        end
    end

    sequence s_enter;
        enter_req ##1 (state == ST_STANDBY);
    endsequence

    sequence s_wake;
        (state == ST_STANDBY) && wake_req ##1 (state == ST_SETTLE);
    endsequence

    property p_align;
        osc_rise && state == ST_RUN |=> phi_en;
    endproperty
    a_align: assert property (p_align)
        else $error("phi did not follow oscillator rise");

    property p_mult;
        osc_rise && state == ST_RUN && $stable(active_factor) &&
        !factor_moved &&
        $past(state) == ST_RUN && period > 8 && $past(osc_level, 8) == 1'b0
        |-> phi_seen <= 3'((3'h1 << active_factor));
    endproperty
    a_mult: assert property (p_mult)
        else $error("too many phi pulses in one oscillator period");

    property p_defer;
        wr_lpc && !factor_switch_mode && !enter_req |=> $stable(active_factor);
    endproperty
    a_defer: assert property (p_defer)
        else $error("factor changed without standby");

    property p_load;
        s_enter |-> active_factor == $past(pending_factor) ##1 !phi_en;
    endproperty
    a_load: assert property (p_load)
        else $error("standby entry did not load factor or stop clock");

    property p_halt;
        state != ST_RUN |=> !phi_en;
    endproperty
    a_halt: assert property (p_halt)
        else $error("clock ran outside run state");

    property p_settle;
        s_wake ##1 (state == ST_SETTLE)[*1] ##0 state == ST_SETTLE
        |-> settle_cnt == (SETTLE_W'(SETTLE_BASE) << settle_time_sel) - 1'b1;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settling count not loaded from select field");

    property p_settle_len;
        state == ST_SETTLE ##1 state == ST_RUN
        |-> settle_elapsed == SETTLE_W'(SETTLE_BASE) << settle_time_sel;
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("settling period length wrong");

    property p_immediate;
        wr_lpc && factor_switch_mode && wr_factor != FACTOR_BAD && !enter_req
        |=> active_factor == $past(wr_factor);
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("factor not applied at once in mode 1");

    property p_codes;
        active_factor != FACTOR_BAD && pending_factor != FACTOR_BAD &&
        bus_clock_sel <= BUS_SEL_LIMIT;
    endproperty
    a_codes: assert property (p_codes)
        else $error("refused code was stored");

    property p_sub;
        sub_en |-> $past(osc_rise) ##1 !sub_en [*8];
    endproperty
    a_sub: assert property (p_sub)
        else $error("subclock pulses too close");

    property p_bus;
        (!bus_clk_en || phi_en) &&
        (!phi_en || bus_clk_en || $past(active_sel) != BUS_SEL_FULL);
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus clock without system clock");

    property p_switch;
        active_sel != $past(active_sel) && $past(state) == ST_RUN
        |-> $past(next_phi) && $past(med_cnt) == 5'h1f;
    endproperty
    a_switch: assert property (p_switch)
        else $error("bus clock source switched off boundary");

endmodule : clock_gen_top

`default_nettype wire

/* verilog/enable_divider.sv */
// Counter of enable pulses that divides their rate by DIV.
// Assumes en is a one-cycle pulse on clk; tick is registered.
`timescale 1ns/1ps
`default_nettype none

module enable_divider
#(
    parameter int unsigned DIV = 2
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic en,
    output logic [$clog2(DIV)-1:0] count,
    output logic tick
);

    localparam int unsigned W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    if (DIV < 2)
    begin : g_bad_div
        $error("enable_divider needs DIV of at least 2");
    end

    // ==================================================================
    // Count and wrap
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= en && (count == LAST);
            if (en)
            begin
                count <= (count == LAST) ? '0 : W'(count + 1'b1);
            end
        end
    end

endmodule : enable_divider

`default_nettype wire

/* verilog/pin_sync.sv */
// Three-stage synchroniser for a pin from outside the clock domain.
// Assumes the pin is slow against clk; a level counts once stages two
// and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin,
    output logic level,
    output logic rise
);

    logic q1;
    logic q2;
    logic q3;

    // ==================================================================
    // Synchroniser chain
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q1 <= 1'b0;
            q2 <= 1'b0;
            q3 <= 1'b0;
        end
        else
        begin
            q1 <= pin;
            q2 <= q1;
            q3 <= q2;
        end
    end

    // ==================================================================
    // Agreed level and its rising edge
    // ==================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            level <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            if (q2 == q3)
            begin
                level <= q2;
            end
            rise <= (q2 == q3) && q2 && !level;
        end
    end

endmodule : pin_sync

`default_nettype wire
